// ### design/led_seq_pkg.sv
package led_seq_pkg;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS  = 50;                           // 20 MHz system clock
   localparam int FSET_LOW_NS    = 7000;                         // Pin low this long counts as held
   localparam int FSET_LOW_CYC   = FSET_LOW_NS / CLK_PERIOD_NS;  // Longest time, rounds down
   localparam int DETECT_MIN_SW  = 3000;                         // Detection window, switching cycles
   localparam int DETECT_MAX_SW  = 4000;
   localparam int DETECT_SW_CYC  = (DETECT_MIN_SW + DETECT_MAX_SW) / 2;
   localparam int NUM_CH         = 8;

   // ==========================================================
   // Sequencer states
   typedef enum logic [2:0] {
      ST_IDLE   = 3'h0,
      ST_GATE   = 3'h1,
      ST_RISE   = 3'h2,
      ST_DETECT = 3'h3,
      ST_SHORT  = 3'h4,
      ST_DONE   = 3'h5
   } seq_state_e;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic [NUM_CH-1:0] above_rise;   // Channel above 120 mV
      logic [NUM_CH-1:0] below_short;  // Channel below 70 mV
      logic [NUM_CH-1:0] above_used;   // Channel above 325 mV
   } led_cmp_s;

   typedef struct packed {
      logic              gate_on;      // Disconnect switch drive
      logic              go;           // Hand-off to soft start
      logic              busy;         // System check in progress
      logic [NUM_CH-1:0] in_use;
      logic [NUM_CH-1:0] unused;
      logic [NUM_CH-1:0] shorted;
   } seq_out_s;

   // ==========================================================
   // Reset values
   localparam seq_out_s   SEQ_OUT_RST   = '0;
   localparam logic [11:0] DET_CNT_RST  = 12'h000;
   localparam logic [7:0]  FSET_CNT_RST = 8'h00;

endpackage

// ### design/level_sync.sv
`timescale 1ns/10ps
// ==========================================================
// Two-stage synchroniser bank for pin-side levels
module level_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset_n,
   // Levels
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_q;

   // First stage feeds only the second stage
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule

// ### design/led_driver_powerup_sequencer.sv
`timescale 1ns/10ps
// Function
// RULE1 - Power-up starts only while enable is high and the supply lockout has cleared.
// RULE2 - The host keeps enable high for the minimum first-pulse width on the first cycle.
// RULE3 - That first-pulse width is 0.75 us typical, 2 us maximum, so hosts hold 2 us.
// RULE4 - Power-up waits while the freq-set/sync pin is held low, until released or clocked.
// RULE5 - A system check for fault conditions runs before any channel is enabled.
// RULE6 - The disconnect switch drive turns on first, then the channels are checked.
// RULE7 - LED detect begins only after the gate comparator reports the switch gate is on.
// RULE8 - After channels pass 120 mV a switching-clock timer runs, then status is latched.
// RULE9 - Below 70 mV is shorted and halts, about 150 mV is unused, above 325 mV is in use.
// RULE10 - A shorted channel blocks soft start; once released the channel is rechecked.
// RULE11 - An unused channel is removed from regulation and from feedback selection.
// RULE12 - Enable falling or lockout asserting returns to idle and drops the gate drive.
// RULE13 - Detection without a short hands an in-use mask and a go to soft start.
module led_driver_powerup_sequencer (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 reset_n,
   // Pins and comparators, asynchronous
   input  wire logic                 en_pwm_pin,
   input  wire logic                 supply_lockout,
   input  wire logic                 freq_set_sync_pin,
   input  wire logic                 gate_cmp_ok,
   input  wire logic                 sw_clk,
   input  wire led_seq_pkg::led_cmp_s led_channel_sink,
   // Sequencer results
   output led_seq_pkg::seq_out_s     seq_out
);
   import led_seq_pkg::*;

   localparam int          SYNC_W    = 5 + 3 * NUM_CH;
   localparam logic [11:0] DET_LAST  = 12'(DETECT_SW_CYC - 1);
   localparam logic [7:0]  FSET_LAST = 8'(FSET_LOW_CYC);

   logic [SYNC_W-1:0] sync_in;
   logic [SYNC_W-1:0] sync_out;
   logic              en_s;
   logic              lock_s;
   logic              fset_s;
   logic              gate_s;
   logic              sw_s;
   led_cmp_s          led_s;
   seq_state_e        state_q;
   seq_state_e        state_d;
   seq_out_s          out_q;
   seq_out_s          out_d;
   logic [11:0]       det_cnt_q;
   logic [7:0]        fset_cnt_q;
   logic              fset_seen_q;
   logic              sw_prev_q;

   // ==========================================================
   // Input synchronisation
   assign sync_in = {en_pwm_pin, supply_lockout, freq_set_sync_pin, gate_cmp_ok, sw_clk,
                     led_channel_sink};

   level_sync #(.WIDTH(SYNC_W)) u_sync (
      .clk     (clk),
      .reset_n (reset_n),
      .d       (sync_in),
      .q       (sync_out)
   );

   assign {en_s, lock_s, fset_s, gate_s, sw_s, led_s} = sync_out;

   // ==========================================================
   // Qualifiers
   wire enable_ok  = en_s & ~lock_s;                        // RULE1
   wire fset_held  = (fset_cnt_q == FSET_LAST);
   wire sw_tick    = sw_s & ~sw_prev_q;                     // Switching-clock rising edge
   wire any_rise   = |led_s.above_rise;
   wire any_short  = |led_s.below_short;
   wire det_done   = sw_tick & (det_cnt_q == DET_LAST);
   wire [NUM_CH-1:0] cls_short  = led_s.below_short;        // RULE9
   wire [NUM_CH-1:0] cls_used   = ~led_s.below_short & led_s.above_used;
   wire [NUM_CH-1:0] cls_unused = ~led_s.below_short & ~led_s.above_used; // RULE11

   // Pin-low watch: a sync clock keeps resetting the count, so only a
   // pin held low saturates it; a high level must be seen before start
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         fset_cnt_q  <= FSET_CNT_RST;
         fset_seen_q <= 1'b0;
         sw_prev_q   <= 1'b0;
      end else begin
         sw_prev_q <= sw_s;
         if (fset_s) begin
            fset_cnt_q  <= FSET_CNT_RST;
            fset_seen_q <= 1'b1;                              // RULE4
         end else if (!fset_held) begin
            fset_cnt_q <= fset_cnt_q + 8'h01;
         end else begin
            fset_seen_q <= 1'b0;                              // RULE4
         end
      end
   end

   // ==========================================================
   // Sequencer next state
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:   if (enable_ok && fset_seen_q) state_d = ST_GATE; // RULE1 RULE4
         ST_GATE:   if (gate_s) state_d = ST_RISE;                   // RULE7
         ST_RISE:   if (any_rise) state_d = ST_DETECT;               // RULE8
         ST_DETECT: if (det_done) state_d = any_short ? ST_SHORT : ST_DONE; // RULE9
         ST_SHORT:  if (!any_short) state_d = ST_DETECT;             // RULE10
         ST_DONE:   state_d = ST_DONE;
         default:   state_d = ST_IDLE;
      endcase
      if (!enable_ok) begin
         state_d = ST_IDLE;                                          // RULE12
      end
   end

   // Outputs follow the next state so they leave flip-flops directly
   always_comb begin
      out_d         = out_q;
      out_d.gate_on = (state_d != ST_IDLE);                          // RULE6 RULE12
      out_d.go      = (state_d == ST_DONE);                          // RULE13
      out_d.busy    = (state_d != ST_IDLE) && (state_d != ST_DONE);  // RULE5
      if (state_d == ST_IDLE) begin
         out_d.in_use  = '0;
         out_d.unused  = '0;
         out_d.shorted = '0;
      end else if (state_q == ST_DETECT && det_done) begin
         out_d.in_use  = cls_used;                                   // RULE13
         out_d.unused  = cls_unused;                                 // RULE11
         out_d.shorted = cls_short;                                  // RULE9
      end
   end

   // ==========================================================
   // State, detection timer and output registers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= ST_IDLE;
         out_q   <= SEQ_OUT_RST;
      end else begin
         state_q <= state_d;
         out_q   <= out_d;
      end
   end

   // Timer counts switching edges only; restarts on every entry to detect
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         det_cnt_q <= DET_CNT_RST;
      end else if (state_q != ST_DETECT) begin
         det_cnt_q <= DET_CNT_RST;
      end else if (sw_tick && !det_done) begin
         det_cnt_q <= det_cnt_q + 12'h001;                           // RULE8
      end
   end

   assign seq_out = out_q;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   property p_start_enable;
      $rose(out_q.gate_on) |-> $past(enable_ok);
   endproperty
   a_start_enable: assert property (p_start_enable) else $error("start without enable"); // RULE1

   property p_start_fset;
      $rose(out_q.gate_on) |-> $past(fset_seen_q);
   endproperty
   a_start_fset: assert property (p_start_fset) else $error("start with pin held low"); // RULE4

   property p_go_after_check;
      $rose(out_q.go) |-> $past(state_q) == ST_DETECT;
   endproperty
   a_go_after_check: assert property (p_go_after_check) else $error("go without check"); // RULE5

   property p_gate_during_detect;
      (state_q == ST_DETECT) |-> out_q.gate_on;
   endproperty
   a_gate_during_detect: assert property (p_gate_during_detect) else $error("gate off"); // RULE6

   // The step out of GATE is taken on the comparator sample of the edge before
   property p_detect_after_gate;
      (state_q == ST_RISE && $past(state_q) == ST_GATE) |-> $past(gate_s);
   endproperty
   a_detect_after_gate: assert property (p_detect_after_gate) else $error("gate not ok"); // RULE7

   property p_timer_length;
      (state_q == ST_DETECT && $past(state_q) == ST_DETECT && state_d != ST_DETECT
       && enable_ok) |-> det_cnt_q == DET_LAST;
   endproperty
   a_timer_length: assert property (p_timer_length) else $error("detect too short"); // RULE8

   property p_classify;
      (state_q == ST_DETECT && det_done && enable_ok) |=>
         out_q.shorted == $past(led_s.below_short) && (out_q.in_use & out_q.unused) == '0;
   endproperty
   a_classify: assert property (p_classify) else $error("bad classification"); // RULE9

   property p_short_recheck;
      (state_q == ST_SHORT && !any_short && enable_ok) |=> state_q == ST_DETECT && !out_q.go;
   endproperty
   a_short_recheck: assert property (p_short_recheck) else $error("no recheck"); // RULE10

   property p_abort;
      !enable_ok |=> !out_q.gate_on && !out_q.go ##1 state_q == ST_IDLE || enable_ok;
   endproperty
   a_abort: assert property (p_abort) else $error("no abort"); // RULE12

   // Idle must never leave the switch drive or a stale mask behind
   property p_idle_clear;
      (state_q == ST_IDLE) |-> !out_q.gate_on && !out_q.busy && out_q.in_use == '0;
   endproperty
   a_idle_clear: assert property (p_idle_clear) else $error("idle not clear"); // RULE12

   property p_go_clean;
      out_q.go |-> out_q.shorted == '0 && out_q.gate_on;
   endproperty
   a_go_clean: assert property (p_go_clean) else $error("go with short"); // RULE13

   c_done:  cover property ($rose(out_q.go));
   c_short: cover property (state_q == ST_SHORT ##1 state_q == ST_DETECT);
   c_abort: cover property (state_q == ST_DETECT ##1 state_q == ST_IDLE);
   c_unused: cover property (out_q.go && out_q.unused != '0);
endmodule

// ### sim/led_far_side.sv
`timescale 1ns/10ps
// ==========================================================
// Far side: gate comparator, free switching clock, channel comparators
module led_far_side (
   // Clock and gate drive
   input  wire logic                            clk,
   input  wire logic                            gate_on,
   // Channel kinds chosen by the scenario
   input  wire logic [led_seq_pkg::NUM_CH-1:0]  short_mask,
   input  wire logic [led_seq_pkg::NUM_CH-1:0]  unused_mask,
   // Comparator levels and switching clock
   output logic                                 gate_cmp_ok,
   output logic                                 sw_clk,
   output led_seq_pkg::led_cmp_s                led_channel_sink
);
   import led_seq_pkg::*;
   // Set at declaration so the clock's first edge at time zero cannot
   // latch an unknown phase that would never clear
   logic [4:0] gate_cnt_q = 5'h00;
   logic [1:0] ph_q = 2'h0;
   initial begin
      gate_cmp_ok = 1'b0;
   end
   // Gate slews for 20 clocks before the comparator trips; a slow gate
   // keeps the detect phase honest about waiting for it
   always @(negedge clk) begin
      ph_q <= ph_q + 2'h1;
      if (!gate_on) begin
         gate_cnt_q <= 5'h00;
      end else if (gate_cnt_q != 5'h14) begin
         gate_cnt_q <= gate_cnt_q + 5'h01;
      end
      gate_cmp_ok <= gate_on && (gate_cnt_q == 5'h14);
   end
   assign sw_clk = ph_q[1];  // 5 MHz switching clock
   // Pins sit at 0 V until the switch is on, then settle per channel kind
   always_comb begin
      led_channel_sink.above_rise  = gate_cmp_ok ? ~short_mask : '0;
      led_channel_sink.below_short = gate_cmp_ok ? short_mask : '1;
      led_channel_sink.above_used  = gate_cmp_ok ? ~(short_mask | unused_mask) : '0;
   end
endmodule

// ### sim/test_led_driver_powerup_sequencer.sv
`timescale 1ns/10ps
// ==========================================================
// Power-up sequencer bench
module test_led_driver_powerup_sequencer;
   import led_seq_pkg::*;
   logic              clk;
   logic              reset_n;
   logic              en_pwm_pin;
   logic              supply_lockout;
   logic              freq_set_sync_pin;
   logic              gate_cmp_ok;
   logic              sw_clk;
   logic [NUM_CH-1:0] short_mask;
   logic [NUM_CH-1:0] unused_mask;
   led_cmp_s          sink;
   seq_out_s          seq_out;
   int                fail_count = 0;
   int                num_checks = 0;

   led_driver_powerup_sequencer uut (.clk(clk), .reset_n(reset_n), .en_pwm_pin(en_pwm_pin),
      .supply_lockout(supply_lockout), .freq_set_sync_pin(freq_set_sync_pin),
      .gate_cmp_ok(gate_cmp_ok), .sw_clk(sw_clk), .led_channel_sink(sink), .seq_out(seq_out));
   led_far_side far (.clk(clk), .gate_on(seq_out.gate_on), .short_mask(short_mask),
      .unused_mask(unused_mask), .gate_cmp_ok(gate_cmp_ok), .sw_clk(sw_clk),
      .led_channel_sink(sink));

   // ==========================================================
   // Helpers
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Bounded wait, the detect length is the only long count
   task automatic wait_go(input int lim);
      for (int i = 0; i < lim && seq_out.go !== 1'b1; i++) @(negedge clk);
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_refuse;
      en_pwm_pin = 1'b1;
      freq_set_sync_pin = 1'b1;
      cyc(30);
      chk("gate_lockout", 8'h00, {7'h00, seq_out.gate_on});
      freq_set_sync_pin = 1'b0;
      cyc(160);
      supply_lockout = 1'b0;
      cyc(30);
      chk("gate_pin_low", 8'h00, {7'h00, seq_out.gate_on});
      freq_set_sync_pin = 1'b1;
      cyc(5);
      chk("gate_start", 8'h01, {7'h00, seq_out.gate_on});
      chk("busy_start", 8'h01, {7'h00, seq_out.busy});
      chk("in_use_early", 8'h00, seq_out.in_use);
   endtask
   task automatic t_normal;
      cyc(13500);
      chk("go_early", 8'h00, {7'h00, seq_out.go});
      wait_go(1500);
      chk("go", 8'h01, {7'h00, seq_out.go});
      chk("in_use", 8'h7F, seq_out.in_use);
      chk("unused", 8'h80, seq_out.unused);
      chk("shorted", 8'h00, seq_out.shorted);
      chk("busy_done", 8'h00, {7'h00, seq_out.busy});
   endtask
   task automatic t_abort(input logic by_lockout);
      if (by_lockout) supply_lockout = 1'b1;
      else en_pwm_pin = 1'b0;
      cyc(4);
      chk("gate_abort", 8'h00, {7'h00, seq_out.gate_on});
      chk("go_abort", 8'h00, {7'h00, seq_out.go});
      chk("in_use_abort", 8'h00, seq_out.in_use);
   endtask
   // Lockout in the middle of detection drops everything before a verdict
   task automatic t_mid_abort;
      supply_lockout = 1'b0;
      cyc(100);
      chk("busy_detect", 8'h01, {7'h00, seq_out.busy});
      chk("go_detect", 8'h00, {7'h00, seq_out.go});
      t_abort(1'b1);
   endtask
   // A short holds power-up; its release starts a fresh detect
   task automatic t_short;
      short_mask = 8'h01;
      unused_mask = 8'h00;
      en_pwm_pin = 1'b1;
      cyc(14600);
      chk("go_short", 8'h00, {7'h00, seq_out.go});
      chk("shorted_ch0", 8'h01, seq_out.shorted);
      short_mask = 8'h00;
      cyc(13000);
      chk("go_recheck", 8'h00, {7'h00, seq_out.go});
      wait_go(2500);
      chk("go_released", 8'h01, {7'h00, seq_out.go});
      chk("in_use_all", 8'hFF, seq_out.in_use);
   endtask

   // ==========================================================
   // Clock, watchdog and main sequence
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      #3000000;
      fail_count++;
      $display("[ERR] watchdog expected done seen timeout");
      complete_run();
   end
   initial begin
      reset_n = 1'b0;
      en_pwm_pin = 1'b0;
      supply_lockout = 1'b1;
      freq_set_sync_pin = 1'b0;
      short_mask = 8'h00;
      unused_mask = 8'h80;
      repeat (6) @(posedge clk);
      @(negedge clk);
      reset_n = 1'b1;
      t_refuse();
      t_normal();
      t_abort(1'b0);
      t_short();
      t_abort(1'b1);
      t_mid_abort();
      complete_run();
   end
endmodule
